// [design/pswfs_top.sv]
/*
  fault and status flag bank of a usb port power controller: fault latching,
  error mode, alert output and switch status, read and written over a plain
  byte-wide register port.
  assumes all inputs are synchronous to clk and that alert_filter,
  alert_join and power_enable_request come from a configuration register
  kept elsewhere.
*/
// Notes on behaviour
// [RULE1] entering error mode sets the error flag.
// [RULE2] writing one to error flag leaves error mode only if no fault remains.
// [RULE3] error mode holds while the reset-indication flag stays set.
// [RULE4] reset-indication flag is set at power-up and drives alert.
// [RULE5] reset-indication clears on write of one or enable pin toggle standalone.
// [RULE6] reset-indication flag is kept unchanged across sleep.
// [RULE7] vbus low sets its flag, raises alert, enters error mode.
// [RULE8] over-temperature sets its flag, raises alert, enters error mode.
// [RULE9] supply overvoltage sets its flag, raises alert, enters error mode.
// [RULE10] overcurrent flag needs current above both limit and region-two minimum.
// [RULE11] fault flags clear on write of one if gone, or with error flag.
// [RULE12] supply undervolt flag follows the level and holds the switch off.
// [RULE13] current-limit status set while limiting, zero when switch is off.
// [RULE14] power-enable status follows the switch control request.
// [RULE15] low charge current flag is sticky, write one clears, alert if joined.
// [RULE16] registers at 403h, 404h, 40fh, eight bits, flags default zero except reset-indication.
// [RULE17] alert drops only after every source of it is gone.
// [RULE18] switch enable is enable pin or software request.
// [RULE19] alert filter passes only overcurrent and thermal faults.
// [RULE20] reserved bits read zero; writing zero leaves flags unchanged.
// [RULE21] a fault in the same cycle as its clear keeps the flag set.
`timescale 1ns/1ps
`include "pswfs_regs.svh"

module pswfs_top
  import pswfs_pkg::*;
(
  input wire logic clk,                   // 40 mhz system clock
  input wire logic resetn,                // synchronous reset, active low
  input wire logic [10:0] reg_addr,       // register byte address
  input wire logic reg_wr,                // write strobe, one cycle
  input wire logic reg_rd,                // read strobe, one cycle
  input wire logic [7:0] reg_wdata,       // write data
  output logic [7:0] reg_rdata,           // read data, valid cycle after reg_rd
  input wire pswfs_sense_t sense,         // analog detector levels
  input wire logic power_enable_pin,      // external power enable pin
  input wire logic power_enable_request,  // software power enable request
  input wire logic standalone_dfp,        // standalone downstream-facing mode
  input wire logic alert_filter,          // pass only overcurrent and thermal
  input wire logic alert_join,            // let low charge current raise alert
  output logic alert,                     // alert output, active high
  output logic error_mode,                // controller in error mode
  output logic switch_on                  // port power switch drive
);

  pswfs_state_t s_q;
  pswfs_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  logic wr_fault;
  logic wr_switch;
  logic [7:0] clr;
  logic oc_live;
  logic any_live;
  logic enable_req;
  logic pin_toggle;

  // write-one-to-clear masks; a zero leaves the flag alone
  assign wr_fault = reg_wr && (reg_addr == `PSWFS_ADDR_FAULT); // RULE16
  assign wr_switch = reg_wr && (reg_addr == `PSWFS_ADDR_SWITCH); // RULE16
  assign clr = reg_wdata; // RULE20

  // overcurrent counts only above both thresholds, so plain limiting is no fault
  assign oc_live = sense.over_limit && sense.over_r2min; // RULE10
  assign any_live = sense.vbus_low || sense.temp_over || sense.supply_ov || oc_live;

  // switch request is the or of pin and software bit
  assign enable_req = power_enable_pin || power_enable_request; // RULE18

  // pin toggle is ignored until one sample was taken after reset
  assign pin_toggle = standalone_dfp && s_q.pin_seen && (power_enable_pin != s_q.pin_prev);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.pin_prev = power_enable_pin;
    s_d.pin_seen = 1'b1;

    // fault flags: a live condition always wins over a clear
    s_d.f_vbl = sense.vbus_low || (s_q.f_vbl && !(wr_fault && clr[`PSWFS_FLT_VBL])); // RULE7 RULE21
    s_d.f_tsd = sense.temp_over || (s_q.f_tsd && !(wr_fault && clr[`PSWFS_FLT_TSD])); // RULE8 RULE21
    s_d.f_ov = sense.supply_ov || (s_q.f_ov && !(wr_fault && clr[`PSWFS_FLT_OV])); // RULE9 RULE21
    s_d.f_oc = oc_live || (s_q.f_oc && !(wr_fault && clr[`PSWFS_FLT_OC])); // RULE10 RULE11

    // only reset sets this flag; sleep does not touch it
    s_d.rst_ind = s_q.rst_ind && !((wr_fault && clr[`PSWFS_FLT_RST]) || pin_toggle); // RULE5 RULE6

    // error mode
    case (s_q.mode)
      PSWFS_ACTIVE: begin
        if (s_q.f_vbl || s_q.f_tsd || s_q.f_ov || s_q.f_oc) begin
          s_d.mode = PSWFS_ERROR; // RULE7 RULE8 RULE9 RULE10
          s_d.err = 1'b1; // RULE1
        end
      end
      PSWFS_ERROR: begin
        s_d.err = 1'b1; // RULE1
        // recheck every condition; the reset flag after this write also blocks
        if (wr_fault && clr[`PSWFS_FLT_ERR] && !any_live && !s_d.rst_ind) begin // RULE2 RULE3
          s_d.mode = PSWFS_ACTIVE;
          s_d.err = 1'b0;
          s_d.f_vbl = 1'b0; // RULE11
          s_d.f_tsd = 1'b0; // RULE11
          s_d.f_ov = 1'b0; // RULE11
          s_d.f_oc = 1'b0; // RULE11
        end
      end
      default: begin
        s_d.mode = PSWFS_ERROR;
        s_d.err = 1'b1;
      end
    endcase

    // supply undervolt is a live level; writes have no lasting effect
    s_d.supply_undervolt_flag = sense.supply_uvlo; // RULE12

    // switch is on only when requested, supply good and not in error
    s_d.sw_on = enable_req && !sense.supply_uvlo && (s_d.mode == PSWFS_ACTIVE); // RULE12 RULE18
    s_d.power_enable_state = enable_req; // RULE14
    s_d.current_limit_active = sense.over_limit && sense.limit_engaged && s_d.sw_on; // RULE13

    // low charge current is sticky until written with one
    s_d.low_charge_current = sense.low_current ||
      (s_q.low_charge_current && !(wr_switch && clr[`PSWFS_SW_LOWCUR])); // RULE15 RULE21

    // alert from the next flag values, so it drops with its last source
    if (alert_filter) begin
      s_d.alert = s_d.f_oc || s_d.f_tsd; // RULE19
    end else begin
      s_d.alert = s_d.err || s_d.rst_ind || s_d.f_vbl || s_d.f_tsd || s_d.f_ov || s_d.f_oc; // RULE4
    end
    s_d.alert = s_d.alert || (alert_join && s_d.low_charge_current); // RULE15 RULE17

    // read path; unmapped addresses and reserved bits read zero
    if (reg_rd) begin
      case (reg_addr)
        `PSWFS_ADDR_FAULT: begin
          s_d.rdata = {s_q.err, 1'b0, s_q.rst_ind, s_q.f_vbl, s_q.f_tsd,
                       s_q.f_ov, 1'b0, s_q.f_oc}; // RULE16 RULE20
        end
        `PSWFS_ADDR_SUPPLY: begin
          s_d.rdata = {2'h0, s_q.supply_undervolt_flag, 5'h00}; // RULE20
        end
        `PSWFS_ADDR_SWITCH: begin
          s_d.rdata = {3'h0, s_q.current_limit_active, s_q.power_enable_state,
                       s_q.low_charge_current, 2'h0}; // RULE20
        end
        default: begin
          s_d.rdata = `PSWFS_RDATA_RST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset sets the reset indication so software knows to reprogram
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q.mode <= PSWFS_ACTIVE;
      s_q.err <= `PSWFS_FLAG_RST;
      s_q.rst_ind <= `PSWFS_RST_IND_POR; // RULE4
      s_q.f_vbl <= `PSWFS_FLAG_RST;
      s_q.f_tsd <= `PSWFS_FLAG_RST;
      s_q.f_ov <= `PSWFS_FLAG_RST;
      s_q.f_oc <= `PSWFS_FLAG_RST;
      s_q.supply_undervolt_flag <= `PSWFS_FLAG_RST;
      s_q.current_limit_active <= `PSWFS_FLAG_RST;
      s_q.power_enable_state <= `PSWFS_FLAG_RST;
      s_q.low_charge_current <= `PSWFS_FLAG_RST;
      s_q.alert <= 1'b1; // RULE4
      s_q.sw_on <= 1'b0;
      s_q.pin_prev <= 1'b0;
      s_q.pin_seen <= 1'b0;
      s_q.rdata <= `PSWFS_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign alert = s_q.alert;
  assign error_mode = s_q.err;
  assign switch_on = s_q.sw_on;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_err_flag_in_error;
    s_q.mode == PSWFS_ERROR |-> s_q.err;
  endproperty
  a_err_flag_in_error: assert property (p_err_flag_in_error) // RULE1
    else $error("error mode without error flag");

  property p_no_exit_live;
    (s_q.mode == PSWFS_ERROR) && wr_fault && clr[`PSWFS_FLT_ERR] && any_live
      |=> s_q.mode == PSWFS_ERROR && s_q.err;
  endproperty
  a_no_exit_live: assert property (p_no_exit_live) // RULE2
    else $error("left error mode with a live fault");

  property p_no_exit_rst;
    (s_q.mode == PSWFS_ERROR) && wr_fault && s_q.rst_ind && !clr[`PSWFS_FLT_RST] && !pin_toggle
      |=> s_q.mode == PSWFS_ERROR;
  endproperty
  a_no_exit_rst: assert property (p_no_exit_rst) // RULE3
    else $error("left error mode while reset flag set");

  property p_rst_alert;
    s_q.rst_ind && !$past(alert_filter) |-> s_q.alert;
  endproperty
  a_rst_alert: assert property (p_rst_alert) // RULE4
    else $error("reset flag set without alert");

  property p_rst_clear;
    wr_fault && clr[`PSWFS_FLT_RST] |=> !s_q.rst_ind;
  endproperty
  a_rst_clear: assert property (p_rst_clear) // RULE5
    else $error("reset flag not cleared by write of one");

  sequence s_vbl_flag;
    s_q.f_vbl;
  endsequence
  sequence s_enter_error;
    s_q.mode == PSWFS_ERROR ##0 s_q.err;
  endsequence
  property p_vbus_fault;
    sense.vbus_low && (s_q.mode == PSWFS_ACTIVE) && !reg_wr
      |=> s_vbl_flag ##1 s_enter_error;
  endproperty
  a_vbus_fault: assert property (p_vbus_fault) // RULE7
    else $error("vbus low did not lead to error mode");

  property p_oc_both;
    $rose(s_q.f_oc) |-> $past(sense.over_limit && sense.over_r2min);
  endproperty
  a_oc_both: assert property (p_oc_both) // RULE10
    else $error("overcurrent flag without both thresholds");

  property p_thermal_wins;
    sense.temp_over |=> s_q.f_tsd;
  endproperty
  a_thermal_wins: assert property (p_thermal_wins) // RULE21
    else $error("thermal flag lost against a clear");

  property p_uvlo_off;
    sense.supply_uvlo |=> s_q.supply_undervolt_flag && !s_q.sw_on;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) // RULE12
    else $error("switch on during supply undervolt");

  property p_cl_off;
    !s_q.sw_on |-> !s_q.current_limit_active;
  endproperty
  a_cl_off: assert property (p_cl_off) // RULE13
    else $error("current limit status with switch off");

  property p_filter;
    $past(alert_filter) && !$past(alert_join) && !s_q.f_oc && !s_q.f_tsd |-> !s_q.alert;
  endproperty
  a_filter: assert property (p_filter) // RULE19
    else $error("filtered alert from a masked source");

endmodule : pswfs_top

// [design/pswfs_regs.svh]
/*
  register addresses, field positions and reset values of the port power
  fault and status bank. assumes an 11-bit byte address and 8-bit data.
*/
`ifndef PSWFS_REGS_SVH
`define PSWFS_REGS_SVH

// register addresses
`define PSWFS_ADDR_FAULT 11'h403
`define PSWFS_ADDR_SUPPLY 11'h404
`define PSWFS_ADDR_SWITCH 11'h40f

// fault_event_flags fields
`define PSWFS_FLT_ERR 7
`define PSWFS_FLT_RST 5
`define PSWFS_FLT_VBL 4
`define PSWFS_FLT_TSD 3
`define PSWFS_FLT_OV 2
`define PSWFS_FLT_OC 0

// supply_low_flags fields
`define PSWFS_SUP_UVLO 5

// switch_state_flags fields
`define PSWFS_SW_CL 4
`define PSWFS_SW_PWREN 3
`define PSWFS_SW_LOWCUR 2

// reset values
`define PSWFS_RST_IND_POR 1'b1
`define PSWFS_FLAG_RST 1'b0
`define PSWFS_RDATA_RST 8'h00

`endif

// [design/pswfs_pkg.sv]
/*
  types of the port power fault and status bank.
  assumes the analog comparators deliver clean levels on the system clock.
*/
package pswfs_pkg;

  // controller mode, one-hot
  typedef enum logic [1:0] {
    PSWFS_ACTIVE = 2'b01,
    PSWFS_ERROR = 2'b10
  } pswfs_mode_t;

  // comparator and detector levels from the analog side
  typedef struct packed {
    logic vbus_low;      // vbus below minimum level
    logic temp_over;     // die above thermal_trip_level
    logic supply_ov;     // supply_sense_voltage above supply_overvoltage_level
    logic over_limit;    // bus current above current_limit_setting
    logic over_r2min;    // bus current above region_two_min_current
    logic supply_uvlo;   // supply_sense_voltage below supply_uvlo_level
    logic limit_engaged; // current limiting circuit active
    logic low_current;   // portable device lowered its charge current
  } pswfs_sense_t;

  // whole state of the bank
  typedef struct packed {
    pswfs_mode_t mode;
    logic err;
    logic rst_ind;
    logic f_vbl;
    logic f_tsd;
    logic f_ov;
    logic f_oc;
    logic supply_undervolt_flag;
    logic current_limit_active;
    logic power_enable_state;
    logic low_charge_current;
    logic alert;
    logic sw_on;
    logic pin_prev;
    logic pin_seen;
    logic [7:0] rdata;
  } pswfs_state_t;

endpackage : pswfs_pkg

// [bench/pswfs_tb.sv]
/*
  self-checking bench of the port power fault and status bank.
  assumes the design's register port takes one-cycle strobes and answers reads
  one edge later; inputs change on the falling edge of clk.
*/
`timescale 1ns/1ps
`include "pswfs_regs.svh"

// one comparison, counted; four-state so an unknown never matches
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
  import pswfs_pkg::*;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] reg_addr = 11'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  pswfs_sense_t sense = pswfs_sense_t'(8'h00);
  logic power_enable_pin = 1'b0;
  logic power_enable_request = 1'b0;
  logic standalone_dfp = 1'b0;
  logic alert_filter = 1'b0;
  logic alert_join = 1'b0;
  logic alert;
  logic error_mode;
  logic switch_on;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] flt_in [4] = '{8'h80, 8'h40, 8'h20, 8'h18};
  logic [7:0] flt_bit [4] = '{8'h10, 8'h08, 8'h04, 8'h01};

  pswfs_top dut (
    .clk(clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sense(sense),
    .power_enable_pin(power_enable_pin),
    .power_enable_request(power_enable_request),
    .standalone_dfp(standalone_dfp),
    .alert_filter(alert_filter),
    .alert_join(alert_join),
    .alert(alert),
    .error_mode(error_mode),
    .switch_on(switch_on)
  );

  // 40 mhz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // one-cycle write strobe; the flags update at the edge in between
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // read data is registered, so it is settled one falling edge later
  task automatic rd(input logic [10:0] a, input logic [7:0] e, input string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK(nm, e, reg_rdata)
  endtask : rd

  // a fault level held for a single edge, then the error mode settles
  task automatic pulse(input logic [7:0] s);
    sense = pswfs_sense_t'(s);
    cyc(1);
    sense = pswfs_sense_t'(8'h00);
    cyc(2);
  endtask : pulse

  task automatic end_of_test;
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // a hang is cut short well beyond the under a hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence

  initial begin
    cyc(2);
    resetn = 1'b1;
    // reset values, unmapped and reserved places
    rd(`PSWFS_ADDR_FAULT, 8'h20, "fault after reset");
    `CHK("alert after reset", 1'b1, alert)
    rd(`PSWFS_ADDR_SUPPLY, 8'h00, "supply after reset");
    rd(`PSWFS_ADDR_SWITCH, 8'h00, "switch after reset");
    wr(11'h405, 8'hff);
    rd(11'h405, 8'h00, "unmapped");
    wr(`PSWFS_ADDR_FAULT, 8'h42);
    rd(`PSWFS_ADDR_FAULT, 8'h20, "zero and reserved write");
    wr(`PSWFS_ADDR_FAULT, 8'h20);
    rd(`PSWFS_ADDR_FAULT, 8'h00, "reset flag cleared");
    `CHK("alert dropped", 1'b0, alert)
    // switch enable by software request
    power_enable_request = 1'b1;
    cyc(2);
    `CHK("switch by request", 1'b1, switch_on)
    rd(`PSWFS_ADDR_SWITCH, 8'h08, "enable status");
    // every fault kind: flag, alert, error mode, switch off, release
    for (int i = 0; i < 4; i++) begin
      pulse(flt_in[i]);
      rd(`PSWFS_ADDR_FAULT, 8'h80 | flt_bit[i], "fault flag");
      `CHK("fault alert", 1'b1, alert)
      `CHK("fault error mode", 1'b1, error_mode)
      `CHK("fault switch off", 1'b0, switch_on)
      wr(`PSWFS_ADDR_FAULT, 8'h80);
      rd(`PSWFS_ADDR_FAULT, 8'h00, "released");
      `CHK("released mode", 1'b0, error_mode)
      `CHK("released alert", 1'b0, alert)
    end
    // release refused while the fault level stays live; set beats clear
    sense = pswfs_sense_t'(8'h80);
    cyc(3);
    wr(`PSWFS_ADDR_FAULT, 8'h90);
    rd(`PSWFS_ADDR_FAULT, 8'h90, "live fault kept");
    `CHK("error held", 1'b1, error_mode)
    sense = pswfs_sense_t'(8'h00);
    cyc(1);
    wr(`PSWFS_ADDR_FAULT, 8'h10);
    rd(`PSWFS_ADDR_FAULT, 8'h80, "flag cleared, mode kept");
    wr(`PSWFS_ADDR_FAULT, 8'h80);
    cyc(2);
    // current above limit only: limiting shows, no overcurrent fault
    sense = pswfs_sense_t'(8'h12);
    cyc(2);
    rd(`PSWFS_ADDR_SWITCH, 8'h18, "limit active");
    rd(`PSWFS_ADDR_FAULT, 8'h00, "no overcurrent");
    // supply undervoltage follows its level and holds the switch off
    sense = pswfs_sense_t'(8'h16);
    cyc(2);
    rd(`PSWFS_ADDR_SUPPLY, 8'h20, "supply low");
    rd(`PSWFS_ADDR_SWITCH, 8'h08, "limit off with switch");
    `CHK("switch held off", 1'b0, switch_on)
    wr(`PSWFS_ADDR_SUPPLY, 8'h20);
    rd(`PSWFS_ADDR_SUPPLY, 8'h20, "supply low not cleared");
    sense = pswfs_sense_t'(8'h00);
    cyc(2);
    rd(`PSWFS_ADDR_SUPPLY, 8'h00, "supply back");
    `CHK("switch back on", 1'b1, switch_on)
    // low charge current: sticky, alert only when joined
    sense = pswfs_sense_t'(8'h01);
    cyc(1);
    sense = pswfs_sense_t'(8'h00);
    cyc(1);
    rd(`PSWFS_ADDR_SWITCH, 8'h0c, "low current");
    `CHK("low current unjoined", 1'b0, alert)
    alert_join = 1'b1;
    cyc(2);
    `CHK("low current joined", 1'b1, alert)
    wr(`PSWFS_ADDR_SWITCH, 8'h1c);
    rd(`PSWFS_ADDR_SWITCH, 8'h08, "low current cleared");
    `CHK("alert after low clear", 1'b0, alert)
    // alert filter passes thermal, not overvoltage
    alert_filter = 1'b1;
    pulse(8'h20);
    `CHK("filtered overvoltage", 1'b0, alert)
    `CHK("filtered still error", 1'b1, error_mode)
    pulse(8'h40);
    `CHK("thermal passes filter", 1'b1, alert)
    wr(`PSWFS_ADDR_FAULT, 8'h80);
    alert_filter = 1'b0;
    // second reset, then enable pin toggle clears the reset flag
    power_enable_request = 1'b0;
    standalone_dfp = 1'b1;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(2);
    rd(`PSWFS_ADDR_FAULT, 8'h20, "reset flag again");
    power_enable_pin = 1'b1;
    cyc(2);
    rd(`PSWFS_ADDR_FAULT, 8'h00, "pin toggle clear");
    `CHK("switch by pin", 1'b1, switch_on)
    rd(`PSWFS_ADDR_SWITCH, 8'h08, "enable by pin");
    // third reset: a set reset flag blocks leaving error mode
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(2);
    pulse(8'h40);
    wr(`PSWFS_ADDR_FAULT, 8'h80);
    rd(`PSWFS_ADDR_FAULT, 8'ha8, "reset flag blocks release");
    `CHK("error held by reset flag", 1'b1, error_mode)
    `CHK("switch off in error", 1'b0, switch_on)
    end_of_test();
  end

endmodule : testbench
